// ===== core/aptc_pkg.sv
`default_nettype none
package aptc_pkg;
    localparam int NUM_PAIRS = 5;
    localparam int NUM_CTRL_REGS = 3;
    localparam int PWM_GENS = 9;
    localparam int ADDR_W = 5;
    localparam int SEL_W = 5;

    // Pair slots: 0 -> pair four, 1 -> six, 2 -> seven, 3 -> eight, 4 -> nine.
    localparam logic [4:0] PAIR_NUMBER [NUM_PAIRS] = '{5'd4, 5'd6, 5'd7, 5'd8, 5'd9};

    localparam logic [ADDR_W-1:0] OFS_CTRL_B = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL_C = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_CTRL_D = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_GLOBAL_TRIG = 5'h14;

    // Byte field layout, repeated in the upper byte for the odd pair.
    localparam int BIT_IRQ_EN = 7;
    localparam int BIT_PEND = 6;
    localparam int BIT_SOFT = 5;
    localparam int SEL_LSB = 0;
    localparam int ODD_BYTE_LSB = 8;

    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [4:0] MASK_RESET = 5'h00;

    localparam logic [4:0] SEL_OFF = 5'h00;
    localparam logic [4:0] SEL_SOFT = 5'h01;
    localparam logic [4:0] SEL_GLOBAL = 5'h02;
    localparam logic [4:0] SEL_SPECIAL = 5'h03;
    localparam logic [4:0] SEL_PRI_FIRST = 5'h04;
    localparam logic [4:0] SEL_PRI_LAST = 5'h0b;
    localparam logic [4:0] SEL_TIMER1 = 5'h0c;
    localparam logic [4:0] SEL_RESERVED = 5'h0d;
    localparam logic [4:0] SEL_SEC_FIRST = 5'h0e;
    localparam logic [4:0] SEL_SEC_LAST = 5'h16;
    localparam logic [4:0] SEL_CL_FIRST = 5'h17;
    localparam logic [4:0] SEL_CL_LAST = 5'h1e;
    localparam logic [4:0] SEL_TIMER2 = 5'h1f;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : aptc_pkg
`default_nettype wire

// ===== core/aptc_trigger_ctrl.sv
`default_nettype none
// Functional notes
// - Raise an interrupt when a pair's conversion completes, only if its enable is set.
// - Set the pair's pending flag when its selected trigger source rises.
// - Clear the pending flag once the pair's conversion completes.
// - Soft start bit starts a soft-selected pair; hardware clears it when pending sets.
// - Selector zero disables the pair; no trigger starts it.
// - Selector one uses the pair's own soft start bit.
// - Selector two uses the global software trigger.
// - Selector three uses the PWM special event trigger.
// - Selectors 4 to 11 pick PWM generator 1 to 8 primary triggers.
// - Selector 12 picks the Timer1 period match; 13 is reserved.
// - Selectors 14 to 22 pick PWM generator 1 to 9 secondary triggers.
// - Selectors 23 to 30 pick PWM generator 1 to 8 current-limit triggers.
// - Selector 31 picks the Timer2 period match.
// - Each pair's controls govern inputs 2n and 2n+1 together.
module aptc_trigger_ctrl
    import aptc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pwm_special_event,
    input wire logic [PWM_GENS-1:0] pwm_primary_trig,
    input wire logic [PWM_GENS-1:0] pwm_secondary_trig,
    input wire logic [PWM_GENS-1:0] pwm_current_limit_trig,
    input wire logic timer1_period_match,
    input wire logic timer2_period_match,
    input wire logic [NUM_PAIRS-1:0] conv_done,
    output logic [NUM_PAIRS-1:0] conv_request,
    output logic [NUM_PAIRS-1:0] pair_irq,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Trigger source decode.

    function automatic logic pick_source(input logic [4:0] sel, input logic own_soft,
            input logic global_soft, input logic special, input logic [PWM_GENS-1:0] pri,
            input logic [PWM_GENS-1:0] sec, input logic [PWM_GENS-1:0] cl,
            input logic t1, input logic t2);
        logic hit;
        hit = 1'b0;
        if (sel == SEL_OFF) begin
            hit = 1'b0;
        end else if (sel == SEL_SOFT) begin
            hit = own_soft;
        end else if (sel == SEL_GLOBAL) begin
            hit = global_soft;
        end else if (sel == SEL_SPECIAL) begin
            hit = special;
        end else if (sel >= SEL_PRI_FIRST && sel <= SEL_PRI_LAST) begin
            hit = pri[4'(sel - SEL_PRI_FIRST)];
        end else if (sel == SEL_TIMER1) begin
            hit = t1;
        end else if (sel == SEL_RESERVED) begin
            hit = 1'b0;
        end else if (sel >= SEL_SEC_FIRST && sel <= SEL_SEC_LAST) begin
            hit = sec[4'(sel - SEL_SEC_FIRST)];
        end else if (sel >= SEL_CL_FIRST && sel <= SEL_CL_LAST) begin
            hit = cl[4'(sel - SEL_CL_FIRST)];
        end else if (sel == SEL_TIMER2) begin
            hit = t2;
        end
        return hit;
    endfunction

    // Maps a control register offset to the pair slot of its low byte.
    function automatic logic [2:0] ctrl_low_slot(input logic [ADDR_W-1:0] addr);
        logic [2:0] slot;
        slot = 3'd0;
        if (addr == OFS_CTRL_C) begin
            slot = 3'd1;
        end else if (addr == OFS_CTRL_D) begin
            slot = 3'd3;
        end
        return slot;
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        return addr == OFS_CTRL_B || addr == OFS_CTRL_C || addr == OFS_CTRL_D
            || addr == OFS_IRQ_STATUS || addr == OFS_IRQ_MASK || addr == OFS_GLOBAL_TRIG;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Per-pair state.

    logic [NUM_PAIRS-1:0] irq_en;
    logic [NUM_PAIRS-1:0] pend;
    logic [NUM_PAIRS-1:0] soft_start;
    logic [4:0] trig_sel [NUM_PAIRS];
    logic [NUM_PAIRS-1:0] trig_hit;
    logic [NUM_PAIRS-1:0] trig_prev;
    logic [NUM_PAIRS-1:0] trig_event;
    logic [NUM_PAIRS-1:0] done_event;
    logic [NUM_PAIRS-1:0] irq_status;
    logic [NUM_PAIRS-1:0] irq_mask;
    logic global_soft;

    // Bus write capture.
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic ctrl_wr;
    logic [2:0] wr_slot;

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign ctrl_wr = wr_fire && (aw_addr == OFS_CTRL_B || aw_addr == OFS_CTRL_C
        || aw_addr == OFS_CTRL_D);
    assign wr_slot = ctrl_wr ? ctrl_low_slot(aw_addr) : 3'd0;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_pair
            // Slot 0 sits alone in the low byte of the first register; others pair up.
            localparam logic [2:0] SLOT = 3'(gi);
            localparam logic IN_HIGH = (gi == 1) || (gi == 3) ? 1'b0 : (gi != 0);
            localparam int LSB = IN_HIGH ? ODD_BYTE_LSB : 0;
            logic own_wr;
            logic [7:0] wbyte;

            assign own_wr = ctrl_wr && w_strb[LSB / 8] && (IN_HIGH ?
                (wr_slot == SLOT - 3'd1) : (wr_slot == SLOT));
            assign wbyte = w_data[LSB +: 8];

            // The pulse on any selected source is caught on its rising edge only.
            assign trig_hit[gi] = pick_source(trig_sel[gi], soft_start[gi], global_soft,
                pwm_special_event, pwm_primary_trig, pwm_secondary_trig,
                pwm_current_limit_trig, timer1_period_match, timer2_period_match);
            assign trig_event[gi] = trig_hit[gi] && !trig_prev[gi] && !pend[gi];
            assign done_event[gi] = pend[gi] && conv_done[gi];

            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    trig_prev[gi] <= 1'b0;
                end else begin
                    trig_prev[gi] <= trig_hit[gi];
                end
            end

            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    irq_en[gi] <= CTRL_RESET[BIT_IRQ_EN];
                    trig_sel[gi] <= CTRL_RESET[SEL_LSB +: SEL_W];
                end else if (own_wr) begin
                    irq_en[gi] <= wbyte[BIT_IRQ_EN];
                    trig_sel[gi] <= wbyte[SEL_LSB +: SEL_W];
                end
            end

            // One pending flag covers both inputs of the pair.
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    pend[gi] <= CTRL_RESET[BIT_PEND];
                end else if (trig_event[gi]) begin
                    pend[gi] <= 1'b1;
                end else if (done_event[gi]) begin
                    pend[gi] <= 1'b0;
                end
            end

            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    soft_start[gi] <= CTRL_RESET[BIT_SOFT];
                end else if (trig_event[gi]) begin
                    soft_start[gi] <= 1'b0;
                end else if (own_wr && wbyte[BIT_SOFT]) begin
                    soft_start[gi] <= 1'b1;
                end
            end

            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    conv_request[gi] <= 1'b0;
                end else begin
                    conv_request[gi] <= trig_event[gi];
                end
            end

            // Set wins over a write-one clear in the same cycle.
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    irq_status[gi] <= 1'b0;
                end else if (done_event[gi] && irq_en[gi]) begin
                    irq_status[gi] <= 1'b1;
                end else if (wr_fire && aw_addr == OFS_IRQ_STATUS && w_strb[0]
                        && w_data[gi]) begin
                    irq_status[gi] <= 1'b0;
                end
            end

            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    pair_irq[gi] <= 1'b0;
                end else begin
                    pair_irq[gi] <= done_event[gi] && irq_en[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_mask <= MASK_RESET;
        end else if (wr_fire && aw_addr == OFS_IRQ_MASK && w_strb[0]) begin
            irq_mask <= w_data[NUM_PAIRS-1:0];
        end
    end

    // The global trigger is a self-clearing strobe shared by all pairs.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            global_soft <= 1'b0;
        end else begin
            global_soft <= wr_fire && aw_addr == OFS_GLOBAL_TRIG && w_strb[0] && w_data[0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel.

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.

    function automatic logic [7:0] pair_byte(input int slot);
        return {irq_en[slot], pend[slot], soft_start[slot], trig_sel[slot]};
    endfunction

    logic [31:0] rd_word;

    always_comb begin
        rd_word = '0;
        unique case (s_axi_araddr)
            OFS_CTRL_B: rd_word = {16'h0000, 8'h00, pair_byte(0)};
            OFS_CTRL_C: rd_word = {16'h0000, pair_byte(2), pair_byte(1)};
            OFS_CTRL_D: rd_word = {16'h0000, pair_byte(4), pair_byte(3)};
            OFS_IRQ_STATUS: rd_word = {27'h0, irq_status};
            OFS_IRQ_MASK: rd_word = {27'h0, irq_mask};
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // aptc_trigger_ctrl
`default_nettype wire

// ===== verification/aptc_trigger_ctrl_properties.sv
`default_nettype none
module aptc_trigger_ctrl_chk
    import aptc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pwm_special_event,
    input wire logic [PWM_GENS-1:0] pwm_primary_trig,
    input wire logic [PWM_GENS-1:0] pwm_secondary_trig,
    input wire logic [PWM_GENS-1:0] pwm_current_limit_trig,
    input wire logic timer1_period_match,
    input wire logic timer2_period_match,
    input wire logic [NUM_PAIRS-1:0] conv_done,
    input wire logic [NUM_PAIRS-1:0] conv_request,
    input wire logic [NUM_PAIRS-1:0] pair_irq,
    input wire logic irq
);
    wire logic src = pwm_special_event | (|pwm_primary_trig) | (|pwm_secondary_trig)
        | (|pwm_current_limit_trig) | timer1_period_match | timer2_period_match;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    chk_req_one_cycle: assert property (
        |conv_request |=> (conv_request & $past(conv_request)) == 5'h00)
        else $error("conv_request held over one cycle");
    chk_req_has_cause: assert property (
        |conv_request |-> $past(src) || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("conv_request without a trigger");
    chk_irq_on_done: assert property (
        |pair_irq |-> (pair_irq & ~$past(conv_done)) == 5'h00)
        else $error("pair_irq without completion");
    chk_irq_one_pulse: assert property (
        |pair_irq |=> (pair_irq & $past(pair_irq)) == 5'h00)
        else $error("pair_irq held over one cycle");
    chk_irq_rise_cause: assert property (
        $rose(irq) |-> $past(|pair_irq) || $past(s_axi_bvalid))
        else $error("irq rose without cause");
    chk_irq_fall_cause: assert property (
        $fell(irq) |-> $past(s_axi_bvalid))
        else $error("irq fell without a write");
    chk_bresp_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped early");
    chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken while response pending");
    cover property (|conv_request);
    cover property (|pair_irq);
    cover property ($rose(irq));
endmodule // aptc_trigger_ctrl_chk
bind aptc_trigger_ctrl aptc_trigger_ctrl_chk i_chk (.mclk(mclk), .rst(rst),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pwm_special_event(pwm_special_event),
    .pwm_primary_trig(pwm_primary_trig), .pwm_secondary_trig(pwm_secondary_trig),
    .pwm_current_limit_trig(pwm_current_limit_trig), .timer1_period_match(timer1_period_match),
    .timer2_period_match(timer2_period_match), .conv_done(conv_done),
    .conv_request(conv_request), .pair_irq(pair_irq), .irq(irq));
`default_nettype wire

// ===== verification/aptc_src_model.sv
`default_nettype none
module aptc_src_model
    import aptc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic fire,
    input wire logic [4:0] code,
    input wire logic stall,
    input wire logic [NUM_PAIRS-1:0] conv_request,
    output logic pwm_special_event,
    output logic [PWM_GENS-1:0] pwm_primary_trig,
    output logic [PWM_GENS-1:0] pwm_secondary_trig,
    output logic [PWM_GENS-1:0] pwm_current_limit_trig,
    output logic timer1_period_match,
    output logic timer2_period_match,
    output logic [NUM_PAIRS-1:0] conv_done
);
    // The reserved code pulses every source at once.
    logic every;
    logic [1:0] cnt [NUM_PAIRS];
    assign every = fire && code == SEL_RESERVED;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pwm_special_event <= 1'b0;
            pwm_primary_trig <= '0;
            pwm_secondary_trig <= '0;
            pwm_current_limit_trig <= '0;
            timer1_period_match <= 1'b0;
            timer2_period_match <= 1'b0;
            conv_done <= '0;
            cnt <= '{default: 2'h0};
        end else begin
            pwm_special_event <= every || (fire && code == SEL_SPECIAL);
            timer1_period_match <= every || (fire && code == SEL_TIMER1);
            timer2_period_match <= every || (fire && code == SEL_TIMER2);
            for (int g = 0; g < PWM_GENS; g++) begin
                pwm_primary_trig[g] <= every || (fire && code == SEL_PRI_FIRST + 5'(g));
                pwm_secondary_trig[g] <= every || (fire && code == SEL_SEC_FIRST + 5'(g));
                pwm_current_limit_trig[g] <= every || (fire && code == SEL_CL_FIRST + 5'(g));
            end
            // The converter ends four cycles after a request, later while stalled.
            for (int s = 0; s < NUM_PAIRS; s++) begin
                if (conv_request[s]) begin
                    cnt[s] <= 2'h3;
                end else if (cnt[s] != 2'h0 && !stall) begin
                    cnt[s] <= cnt[s] - 2'h1;
                end
                conv_done[s] <= cnt[s] == 2'h1 && !stall;
            end
        end
    end
endmodule // aptc_src_model
`default_nettype wire

// ===== verification/adc_pair_trigger_control_test.sv
`default_nettype none
module adc_pair_trigger_control_test
    import aptc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, awvalid, wvalid, bready, arvalid, rready, fire, stall, clr, irq;
    logic awready, wready, bvalid, arready, rvalid;
    logic [4:0] awaddr, araddr, code;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, resp;
    logic spec, t1, t2;
    logic [PWM_GENS-1:0] pri, sec, cl;
    logic [NUM_PAIRS-1:0] done, req, pirq, seen, twice, irq_seen;
    int n_fail = 0;
    int compares = 0;
    aptc_trigger_ctrl i_dut (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pwm_special_event(spec), .pwm_primary_trig(pri), .pwm_secondary_trig(sec),
        .pwm_current_limit_trig(cl), .timer1_period_match(t1), .timer2_period_match(t2),
        .conv_done(done), .conv_request(req), .pair_irq(pirq), .irq(irq));
    aptc_src_model i_src (.mclk(mclk), .rst(rst), .fire(fire), .code(code), .stall(stall),
        .conv_request(req), .pwm_special_event(spec), .pwm_primary_trig(pri),
        .pwm_secondary_trig(sec), .pwm_current_limit_trig(cl), .timer1_period_match(t1),
        .timer2_period_match(t2), .conv_done(done));
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        if (clr) begin
            seen <= '0;
            twice <= '0;
            irq_seen <= '0;
        end else begin
            twice <= twice | (seen & req);
            seen <= seen | req;
            irq_seen <= irq_seen | pirq;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        resp = bresp;
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        d = rdata;
        resp = rresp;
    endtask
    task automatic clear_mon;
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
    endtask
    task automatic fire_src(input logic [4:0] c);
        @(posedge mclk);
        fire <= 1'b1;
        code <= c;
        @(posedge mclk);
        fire <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] d;
        for (int i = 0; i < 5; i++) begin
            rd(5'(i * 4), d);
            chk({d[31:2], resp}, {30'h0, RESP_OKAY});
        end
        rd(5'h18, d);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        wr(5'h18, 32'hffff_ffff);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        wr(OFS_CTRL_D, 32'hffff_ffff);
        rd(OFS_CTRL_D, d);
        chk(d, 32'h0000_bfbf);
        wr(OFS_CTRL_D, 32'h0);
    endtask
    task automatic t_sweep;
        logic [4:0] c, other, fc;
        logic [4:0] exp;
        for (int i = 0; i < 32; i++) begin
            c = 5'(i);
            other = (c == SEL_TIMER2) ? SEL_TIMER1 : SEL_TIMER2;
            fc = (c == SEL_OFF) ? SEL_RESERVED : c;
            clear_mon;
            wr(OFS_CTRL_C, {16'h0, 3'b000, c, 3'b000, c} | ((c == SEL_SOFT) ? 32'h2020 : 32'h0));
            wr(OFS_CTRL_D, {27'h0, other});
            if (c == SEL_GLOBAL) wr(OFS_GLOBAL_TRIG, 32'h1);
            else if (c != SEL_SOFT) fire_src(fc);
            wait_n(12);
            exp = (c == SEL_OFF || c == SEL_RESERVED) ? 5'h00 : 5'h06;
            exp[3] = (fc == other || fc == SEL_RESERVED);
            chk({22'h0, twice, seen}, {22'h0, 5'h00, exp});
        end
    endtask
    task automatic t_soft;
        logic [31:0] d;
        clear_mon;
        stall <= 1'b1;
        wr(OFS_CTRL_B, 32'h0000_00a1);
        wait_n(4);
        rd(OFS_CTRL_B, d);
        chk(d, 32'h0000_00c1);
        stall <= 1'b0;
        wait_n(12);
        rd(OFS_CTRL_B, d);
        chk(d, 32'h0000_0081);
        rd(OFS_IRQ_STATUS, d);
        chk(d, 32'h0000_0001);
        chk({21'h0, irq, irq_seen, seen}, {21'h0, 1'b0, 5'h01, 5'h01});
        wr(OFS_IRQ_MASK, 32'h1);
        wait_n(2);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_STATUS, 32'h1);
        wait_n(2);
        chk({31'h0, irq}, 32'h0);
        clear_mon;
        wr(OFS_CTRL_B, 32'h0000_0021);
        wait_n(12);
        chk({21'h0, irq, irq_seen, seen}, {21'h0, 1'b0, 5'h00, 5'h01});
    endtask
    task automatic t_hold;
        logic [31:0] d;
        clear_mon;
        stall <= 1'b1;
        wr(OFS_CTRL_C, {27'h0, SEL_TIMER1});
        fire_src(SEL_TIMER1);
        wait_n(4);
        fire_src(SEL_TIMER1);
        wait_n(4);
        rd(OFS_CTRL_C, d);
        chk(d, 32'h0000_004c);
        // Pair eight still selects the Timer1 match from the sweep, so it fires alongside.
        chk({22'h0, twice, seen}, {22'h0, 5'h00, 5'h0a});
        stall <= 1'b0;
        wait_n(12);
        clear_mon;
        fire_src(SEL_TIMER1);
        wait_n(8);
        chk({22'h0, twice, seen}, {22'h0, 5'h00, 5'h0a});
    endtask
    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        stop_test;
    end
    initial begin
        {mclk, awvalid, wvalid, bready, arvalid, rready, fire, stall} = '0;
        {awaddr, araddr, code, wdata} = '0;
        rst = 1'b1;
        clr = 1'b1;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        clr <= 1'b0;
        t_reset;
        t_sweep;
        t_soft;
        t_hold;
        stop_test;
    end
endmodule // adc_pair_trigger_control_test
`default_nettype wire
